// file: bench/gppi_chk.sv
// Port checker for the poll interrupt block
`timescale 1ns/1ps
`include "gppi_regs.svh"
module gppi_chk (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire gppi_pkg::gppi_cpu_req_t cpu_req,
   input wire logic cpu_io_cycle,
   input wire logic cpu_cycle_active,
   input wire logic [7:0] cpu_rdata,
   input wire logic cpu_stall,
   input wire gppi_pkg::gppi_local_drive_t local_drive,
   input wire logic irq_level3,
   input wire logic dma_channel0_enable
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   logic [4:0] stall_cnt;
   logic ctl_wr;
   assign ctl_wr = cpu_req.wr && !cpu_stall && cpu_req.addr == `GPPI_ADDR_CTRL_STATUS;
   // Length of the current hold-off run
   always_ff @(posedge ref_clk) begin
      stall_cnt <= cpu_stall ? stall_cnt + 5'h01 : 5'h00;
   end
   sequence s_irq_gone;
      ##2 !irq_level3;
   endsequence
   a_own_sel: assert property (local_drive.oe |-> local_drive.sel == 3'h6 && local_drive.rd)
      else $error("poll register not selected");
   a_take_cycle: assert property (
      $rose(local_drive.oe) |-> $past(cpu_cycle_active && !cpu_io_cycle))
      else $error("bus taken without outside cycle");
   a_stall_len: assert property ($fell(cpu_stall) |-> stall_cnt inside {[16:18]})
      else $error("hold-off length wrong");
   a_stall_free: assert property ($fell(cpu_stall) |-> !local_drive.oe)
      else $error("bus still held after hold-off");
   a_irq_hit: assert property (
      $rose(irq_level3) |-> $past(local_drive.oe, 2) && !$past(local_drive.oe))
      else $error("interrupt without release");
   a_no_resample: assert property (irq_level3 |-> !local_drive.oe)
      else $error("bus taken while pending");
   a_irq_gone: assert property (
      ctl_wr && !(cpu_req.wdata[6] && cpu_req.wdata[7]) |-> s_irq_gone)
      else $error("interrupt stays after clear");
   a_ctl_zero: assert property (
      cpu_req.rd && cpu_req.addr == `GPPI_ADDR_CTRL_STATUS |=> cpu_rdata[5:0] == 6'h00)
      else $error("low control bits not zero");
   a_dma_bit: assert property (
      cpu_req.wr && !cpu_stall && cpu_req.addr == `GPPI_ADDR_SUPPORT
      |=> dma_channel0_enable == $past(cpu_req.wdata[0]))
      else $error("dma enable not written");
endmodule
bind gppi_top gppi_chk i_chk (.ref_clk, .rstn, .cpu_req, .cpu_io_cycle, .cpu_cycle_active,
   .cpu_rdata, .cpu_stall, .local_drive, .irq_level3, .dma_channel0_enable);

// file: bench/gppi_ctrl_model.sv
// Bus controller model answering reads of its poll register
`timescale 1ns/1ps
module gppi_ctrl_model (
   input wire logic ref_clk,
   input wire gppi_pkg::gppi_local_drive_t local_drive,
   input wire logic [7:0] resp,
   output logic [7:0] poll_data
);
   initial poll_data = 8'h5A;
   // Unselected lines keep changing so nothing stale looks valid
   always @(posedge ref_clk) begin
      if (local_drive.oe && local_drive.rd && local_drive.sel == 3'h6) begin
         poll_data <= resp;
      end else begin
         poll_data <= ~poll_data;
      end
   end
endmodule

// file: bench/gppi_parallel_poll_irq_tb.sv
// Self-checking bench for the parallel poll interrupt block
`timescale 1ns/1ps
`include "gppi_regs.svh"
module gppi_parallel_poll_irq_tb;
   localparam logic [23:0] ctl = `GPPI_ADDR_CTRL_STATUS;
   localparam logic [23:0] msk = `GPPI_ADDR_LINE_MASK;
   logic ref_clk;
   logic rstn = 1'b0;
   gppi_pkg::gppi_cpu_req_t cpu_req = '0;
   logic io = 1'b0;
   logic act = 1'b0;
   logic [7:0] cpu_rdata;
   logic cpu_stall;
   logic [7:0] poll_data;
   logic [7:0] resp = 8'h00;
   gppi_pkg::gppi_local_drive_t ld;
   logic irq;
   logic dma;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   int n;
   gppi_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .cpu_req(cpu_req), .cpu_io_cycle(io),
      .cpu_cycle_active(act), .cpu_rdata(cpu_rdata), .cpu_stall(cpu_stall),
      .poll_data(poll_data), .local_drive(ld), .irq_level3(irq), .dma_channel0_enable(dma));
   gppi_ctrl_model i_ctrl (.ref_clk(ref_clk), .local_drive(ld), .resp(resp),
      .poll_data(poll_data));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic end_of_test();
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask
   task automatic wr(input logic [23:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cpu_req <= '{addr: a, wdata: d, rd: 1'b0, wr: 1'b1};
      @(posedge ref_clk);
      cpu_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [23:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      cpu_req <= '{addr: a, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
      @(posedge ref_clk);
      cpu_req.rd <= 1'b0;
      #1 chk("cpu_rdata", e, cpu_rdata);
   endtask
   // One processor cycle outside the I/O subsystem, then a poll window
   // Waits first so an earlier bus release has ended and the cycle is seen
   task automatic poll(input logic [7:0] m, input logic [7:0] r, input logic e);
      repeat (20) @(posedge ref_clk);
      wr(msk, m);
      resp <= r;
      wr(ctl, 8'h80);
      act <= 1'b1;
      repeat (3) @(posedge ref_clk);
      act <= 1'b0;
      repeat (12) @(posedge ref_clk);
      #1 chk("irq_level3", {7'h00, e}, {7'h00, irq});
   endtask
   initial begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      #1 chk("outputs", 8'h00, {irq, cpu_stall, dma, ld});
      rd(ctl, 8'h00);
      wr(msk, 8'hA5);
      rd(msk, 8'hA5);
      wr(ctl, 8'hFF);
      rd(ctl, 8'h80);
      wr(ctl, 8'h00);
      wr(`GPPI_ADDR_SUPPORT, 8'hFF);
      rd(`GPPI_ADDR_SUPPORT, 8'h01);
      chk("dma", 8'h01, {7'h00, dma});
      wr(`GPPI_ADDR_SUPPORT, 8'h00);
      rd(24'h470011, 8'h00);
      poll(8'hFF, 8'h00, 1'b0);
      wr(ctl, 8'h00);
      for (int i = 0; i < 8; i++) begin
         poll(~(8'h01 << i), 8'h01 << i, 1'b0);
         wr(ctl, 8'h00);
         poll(8'h01 << i, 8'h01 << i, 1'b1);
         rd(ctl, 8'hC0);
         wr(ctl, 8'h40);
         rd(ctl, 8'h40);
         chk("irq_level3", 8'h00, {7'h00, irq});
         wr(ctl, 8'h80);
         rd(ctl, 8'h80);
         wr(ctl, 8'h00);
      end
      poll(8'h00, 8'hFF, 1'b0);
      @(posedge ref_clk);
      io <= 1'b1;
      act <= 1'b1;
      n = 0;
      repeat (30) begin
         @(posedge ref_clk);
         #1 if (cpu_stall === 1'b1) n++;
      end
      chk("stall_cycles", 8'd16, n[7:0]);
      chk("oe", 8'h00, {7'h00, ld.oe});
      @(posedge ref_clk);
      io <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 chk("oe", 8'h01, {7'h00, ld.oe});
      wr(ctl, 8'h00);
      act <= 1'b0;
      end_of_test();
   end
endmodule

// file: hw/gppi_pkg.sv
// Types shared by the parallel poll interrupt block
package gppi_pkg;

   typedef enum logic [2:0] {
      GPPI_IDLE,
      GPPI_WAIT_CYCLE,
      GPPI_SETTLE,
      GPPI_SAMPLE,
      GPPI_RELEASE,
      GPPI_WAIT_IO_END,
      GPPI_WAIT_CLEAR
   } gppi_state_t;

   typedef struct packed {
      logic [23:0] addr;
      logic [7:0] wdata;
      logic rd;
      logic wr;
   } gppi_cpu_req_t;

   typedef struct packed {
      logic oe;
      logic [2:0] sel;
      logic rd;
   } gppi_local_drive_t;

endpackage

// file: hw/gppi_regs.svh
// Register offsets, field positions, reset values and timing counts for the poll interrupt block
`ifndef GPPI_REGS_SVH
`define GPPI_REGS_SVH

`define GPPI_ADDR_SUPPORT 24'h470003
`define GPPI_ADDR_CTRL_STATUS 24'h470007
`define GPPI_ADDR_LINE_MASK 24'h470009

`define GPPI_BIT_ENABLE 7
`define GPPI_BIT_PENDING 6
`define GPPI_BIT_DMA_EN 0

`define GPPI_RESET_MASK 8'h00
`define GPPI_POLL_REG_SEL 3'h6

`define GPPI_CLK_MHZ 20
`define GPPI_HOLD_MIN_NS 800
`define GPPI_HOLD_MAX_NS 900
// Release time: least 800 ns rounds up to 16 cycles at 50 ns
`define GPPI_HOLD_CYCLES ((`GPPI_HOLD_MIN_NS * `GPPI_CLK_MHZ + 999) / 1000)
`define GPPI_SETTLE_NS 150
`define GPPI_SETTLE_CYCLES ((`GPPI_SETTLE_NS * `GPPI_CLK_MHZ + 999) / 1000)

`endif

// file: hw/gppi_sync.sv
// Two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/1ps
module gppi_sync #(
   parameter int WIDTH = 8
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// file: hw/gppi_top.sv
// Parallel poll interrupt generator with control, mask and support registers
`timescale 1ns/1ps
`include "gppi_regs.svh"

// Overview of operation
// R1: Control bit 7 enables poll interrupts.
// R2: Bit 6 sets when response detected.
// R3: Writing zero to bit 6 clears it.
// R4: Control bits 5..0 read zero, ignore writes.
// R5: Mask register; zero bit ignores line.
// R6: Mask bit 7 is line 8, down.
// R7: Response is logic one on unmasked line.
// R8: Wait for non-I/O cycle before taking bus.
// R9: Select register 6, await data, then sample.
// R10: Stall I/O access 800-900 ns while releasing.
// R11: After I/O cycle, wait for next cycle.
// R12: Response asserts interrupt level 3.
// R13: Release local bus when raising interrupt.
// R14: No resampling until pending flag cleared.
// R15: Software never enables DMA with polling.
// R16: Support bit 0 enables channel 0 DMA.
// R17: Interrupt driven only when pending and enabled.
// R18: Reset clears flags, idles, releases bus.
module gppi_top (
   ref_clk,
   rstn,
   cpu_req,
   cpu_io_cycle,
   cpu_cycle_active,
   cpu_rdata,
   cpu_stall,
   poll_data,
   local_drive,
   irq_level3,
   dma_channel0_enable
);
   input wire logic ref_clk;
   input wire logic rstn;
   input wire gppi_pkg::gppi_cpu_req_t cpu_req;
   input wire logic cpu_io_cycle;
   input wire logic cpu_cycle_active;
   output logic [7:0] cpu_rdata;
   output logic cpu_stall;
   input wire logic [7:0] poll_data;
   output gppi_pkg::gppi_local_drive_t local_drive;
   output logic irq_level3;
   output logic dma_channel0_enable;

   localparam logic [4:0] HOLD_CYCLES = 5'(`GPPI_HOLD_CYCLES);
   localparam logic [4:0] SETTLE_CYCLES = 5'(`GPPI_SETTLE_CYCLES);

   gppi_pkg::gppi_state_t state;
   gppi_pkg::gppi_state_t next_state;
   logic poll_irq_enable;
   logic poll_irq_pending;
   logic [7:0] poll_line_mask;
   logic [4:0] wait_count;
   logic [7:0] data_sync;
   logic response_hit;
   logic sel_ctrl;
   logic sel_mask;
   logic sel_support;
   logic count_done;

   // Poll data lines arrive from the pins
   gppi_sync #(.WIDTH(8)) u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .async_in(poll_data),
      .sync_out(data_sync)
   );

   assign sel_ctrl = cpu_req.addr == `GPPI_ADDR_CTRL_STATUS;
   assign sel_mask = cpu_req.addr == `GPPI_ADDR_LINE_MASK;
   assign sel_support = cpu_req.addr == `GPPI_ADDR_SUPPORT;
   assign count_done = wait_count == 5'h00;

   // Bit i of the mask gates data line i+1
   assign response_hit = |(data_sync & poll_line_mask); // R5 R6 R7

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         poll_irq_enable <= 1'b0; // R18
      end else if (cpu_req.wr && sel_ctrl && !cpu_stall) begin
         poll_irq_enable <= cpu_req.wdata[`GPPI_BIT_ENABLE]; // R1
      end
   end

   // Hardware set wins over a software acknowledge
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         poll_irq_pending <= 1'b0; // R18
      end else if (state == gppi_pkg::GPPI_SAMPLE && response_hit) begin
         poll_irq_pending <= 1'b1; // R2
      end else if (cpu_req.wr && sel_ctrl && !cpu_stall
                   && !cpu_req.wdata[`GPPI_BIT_PENDING]) begin
         poll_irq_pending <= 1'b0; // R3
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         poll_line_mask <= `GPPI_RESET_MASK;
      end else if (cpu_req.wr && sel_mask && !cpu_stall) begin
         poll_line_mask <= cpu_req.wdata; // R5
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         dma_channel0_enable <= 1'b0;
      end else if (cpu_req.wr && sel_support && !cpu_stall) begin
         dma_channel0_enable <= cpu_req.wdata[`GPPI_BIT_DMA_EN]; // R16
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cpu_rdata <= 8'h00;
      end else if (cpu_req.rd) begin
         if (sel_ctrl) begin
            cpu_rdata <= {poll_irq_enable, poll_irq_pending, 6'h00}; // R4
         end else if (sel_mask) begin
            cpu_rdata <= poll_line_mask;
         end else if (sel_support) begin
            cpu_rdata <= {7'h00, dma_channel0_enable};
         end else begin
            cpu_rdata <= 8'h00;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         irq_level3 <= 1'b0;
      end else begin
         irq_level3 <= poll_irq_pending && poll_irq_enable; // R12 R17
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         gppi_pkg::GPPI_IDLE: begin
            if (poll_irq_enable && !poll_irq_pending) begin
               next_state = gppi_pkg::GPPI_WAIT_CYCLE;
            end
         end
         gppi_pkg::GPPI_WAIT_CYCLE: begin
            if (!poll_irq_enable) begin
               next_state = gppi_pkg::GPPI_IDLE;
            end else if (cpu_cycle_active && !cpu_io_cycle) begin
               next_state = gppi_pkg::GPPI_SETTLE; // R8
            end
         end
         gppi_pkg::GPPI_SETTLE: begin
            if (cpu_io_cycle || !poll_irq_enable) begin
               next_state = gppi_pkg::GPPI_RELEASE;
            end else if (count_done) begin
               next_state = gppi_pkg::GPPI_SAMPLE; // R9
            end
         end
         gppi_pkg::GPPI_SAMPLE: begin
            if (response_hit || cpu_io_cycle || !poll_irq_enable) begin
               next_state = gppi_pkg::GPPI_RELEASE; // R13
            end
         end
         gppi_pkg::GPPI_RELEASE: begin
            if (count_done) begin
               next_state = gppi_pkg::GPPI_WAIT_IO_END; // R10
            end
         end
         gppi_pkg::GPPI_WAIT_IO_END: begin
            if (!cpu_io_cycle) begin
               next_state = poll_irq_pending ? gppi_pkg::GPPI_WAIT_CLEAR
                                             : gppi_pkg::GPPI_IDLE; // R11
            end
         end
         gppi_pkg::GPPI_WAIT_CLEAR: begin
            if (!poll_irq_pending) begin
               next_state = gppi_pkg::GPPI_IDLE; // R14
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state <= gppi_pkg::GPPI_IDLE; // R18
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         wait_count <= 5'h00;
      end else if (next_state != state) begin
         if (next_state == gppi_pkg::GPPI_SETTLE) begin
            wait_count <= SETTLE_CYCLES - 5'h01;
         end else if (next_state == gppi_pkg::GPPI_RELEASE) begin
            wait_count <= HOLD_CYCLES - 5'h01;
         end else begin
            wait_count <= 5'h00;
         end
      end else if (!count_done) begin
         wait_count <= wait_count - 5'h01;
      end
   end

   // Local bus is driven only while borrowed
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         local_drive <= '0; // R18
      end else if (next_state == gppi_pkg::GPPI_SETTLE
                   || next_state == gppi_pkg::GPPI_SAMPLE) begin
         local_drive.oe <= 1'b1;
         local_drive.sel <= `GPPI_POLL_REG_SEL; // R9
         local_drive.rd <= 1'b1;
      end else begin
         local_drive <= '0; // R13
      end
   end

   // I/O access held while the bus is borrowed or being freed
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cpu_stall <= 1'b0;
      end else begin
         cpu_stall <= cpu_io_cycle
                      && (next_state == gppi_pkg::GPPI_SETTLE
                          || next_state == gppi_pkg::GPPI_SAMPLE
                          || next_state == gppi_pkg::GPPI_RELEASE); // R10
      end
   end

endmodule
